// ---- src/msc_check.sv ----
// Purpose: Monitor-mode entry security check with extended lock
// Assumes: Flash read answers one cycle after flash_rd; host bytes arrive
//   as one-cycle strobes in address order
// Notes: Lock bit lives in flash; mass erase is the only way to clear it
module msc_check (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic clk_en, // Freezes all state when low
  input wire logic start, // Begin check on monitor entry
  input wire logic forced_mode, // Forced monitor mode
  input wire logic host_valid, // Host byte strobe
  input wire logic [7:0] host_byte, // Supplied security byte
  input wire logic mass_erase_req, // Mass erase request from monitor
  output logic flash_rd, // Flash read strobe
  output logic [15:0] flash_addr, // Flash read address
  input wire logic [7:0] flash_data, // Flash data, one cycle after read
  output logic erase_go, // Mass erase pulse to flash
  output logic sec_pass, // Check passed, monitor serves commands
  output logic sec_fail, // Check failed
  output logic mon_halt, // Monitor halted in endless loop
  output logic done, // Check finished
  output logic [15:0] baud_div, // Link divider
  output logic [7:0] osc_trim // Applied oscillator trim
);
  import msc_pkg::*;

  // Zero-byte test shared by lock decode and zero counting
  function automatic logic is_zero(input logic [7:0] b);
    return b == 8'h00;
  endfunction

  typedef struct packed {
    msc_state_e st;
    logic [3:0] idx;
    logic [3:0] zeros;
    logic all_eq;
    logic locked;
    logic [7:0] stored;
    logic have;
    logic trim_phase;
    logic flash_rd;
    logic [15:0] flash_addr;
    logic erase_go;
    logic sec_pass;
    logic sec_fail;
    logic mon_halt;
    logic done;
    logic [15:0] baud_div;
    logic [7:0] osc_trim;
  } msc_s;

  msc_s r, next_r;

  always_comb begin
    next_r = r;
    next_r.flash_rd = 1'b0;
    next_r.erase_go = 1'b0;
    unique case (r.st)
      MSC_IDLE: begin
        if (start) begin
          next_r.st = MSC_LOCK;
          next_r.flash_rd = 1'b1;
          next_r.flash_addr = EXT_LOCK_ADDR;
          next_r.trim_phase = forced_mode;
          next_r.idx = IDX_RESET;
          next_r.zeros = 4'h0;
          next_r.all_eq = 1'b1;
          next_r.have = 1'b0;
          next_r.sec_pass = 1'b0;
          next_r.sec_fail = 1'b0;
          next_r.done = 1'b0;
          next_r.baud_div = forced_mode ? BAUD_DIV : r.baud_div;
        end
      end
      MSC_LOCK: begin
        if (r.trim_phase) begin
          // Lock byte is read before trim and again after it; trim is applied before bytes arrive
          if (!r.flash_rd && r.flash_addr == TRIM_ADDR) begin
            next_r.osc_trim = flash_data;
            next_r.trim_phase = 1'b0;
            next_r.flash_rd = 1'b1;
            next_r.flash_addr = EXT_LOCK_ADDR;
          end else if (!r.flash_rd) begin
            next_r.locked = is_zero(flash_data);
            next_r.flash_rd = 1'b1;
            next_r.flash_addr = TRIM_ADDR;
          end
        end else if (!r.flash_rd) begin
          if (r.flash_addr == EXT_LOCK_ADDR) begin
            next_r.locked = is_zero(flash_data);
          end
          next_r.st = MSC_CMP;
          next_r.flash_rd = 1'b1;
          next_r.flash_addr = SEC_FIRST_ADDR;
        end
      end
      MSC_CMP: begin
        if (!r.flash_rd && !r.have) begin
          next_r.stored = flash_data;
          next_r.have = 1'b1;
          if (is_zero(flash_data)) begin
            next_r.zeros = r.zeros + 4'h1;
          end
        end
        if (r.have && host_valid) begin
          next_r.have = 1'b0;
          if (host_byte != r.stored) begin
            next_r.all_eq = 1'b0;
          end
          // Byte count ends the walk, so pairing follows idx
          if (r.idx == 4'(SEC_BYTES - 1)) begin
            next_r.st = MSC_FAIL;
            if (r.all_eq && host_byte == r.stored && r.zeros <= MAX_ZERO_BYTES) begin
              next_r.st = r.locked ? MSC_HALT : MSC_PASS;
            end
          end else begin
            next_r.idx = r.idx + 4'h1;
            next_r.flash_rd = 1'b1;
            next_r.flash_addr = r.flash_addr + 16'h0001;
          end
        end
      end
      MSC_PASS: begin
        next_r.sec_pass = 1'b1;
        next_r.done = 1'b1;
        next_r.st = MSC_IDLE;
      end
      MSC_FAIL: begin
        next_r.sec_fail = 1'b1;
        next_r.done = 1'b1;
        // Erase honoured only after a failed check
        if (mass_erase_req && r.sec_fail) begin
          next_r.erase_go = 1'b1;
          next_r.locked = 1'b0;
          next_r.sec_fail = 1'b0;
          next_r.st = MSC_IDLE;
        end
      end
      MSC_HALT: begin
        // Endless loop: only reset leaves this state
        next_r.mon_halt = 1'b1;
        next_r.done = 1'b1;
      end
      default: next_r.st = MSC_IDLE;
    endcase
  end

  // Freeze holds state, not the flash answer: keep clk_en high while a read is pending
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '{st: MSC_IDLE, idx: IDX_RESET, zeros: 4'h0, all_eq: 1'b1, locked: 1'b0,
             stored: 8'h00, have: 1'b0, trim_phase: 1'b0, flash_rd: 1'b0,
             flash_addr: 16'h0000, erase_go: 1'b0, sec_pass: 1'b0, sec_fail: 1'b0,
             mon_halt: 1'b0, done: 1'b0, baud_div: BAUD_DIV, osc_trim: TRIM_RESET};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign flash_rd = r.flash_rd;
  assign flash_addr = r.flash_addr;
  assign erase_go = r.erase_go;
  assign sec_pass = r.sec_pass;
  assign sec_fail = r.sec_fail;
  assign mon_halt = r.mon_halt;
  assign done = r.done;
  assign baud_div = r.baud_div;
  assign osc_trim = r.osc_trim;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence halt_s;
    mon_halt && clk_en;
  endsequence

  halt_sticky_a: assert property (halt_s |=> mon_halt)
    else $error("halt left without reset");
  halt_needs_lock_a: assert property ($rose(mon_halt) |-> r.locked)
    else $error("halt without lock");
  erase_after_fail_a: assert property (erase_go |-> $past(sec_fail))
    else $error("erase without failed check");
  lock_addr_a: assert property (r.st == MSC_LOCK && flash_rd && !r.trim_phase
    |-> flash_addr == EXT_LOCK_ADDR)
    else $error("lock read wrong address");
  zero_limit_a: assert property ($rose(sec_pass) |-> r.zeros <= MAX_ZERO_BYTES)
    else $error("pass with too many zeros");
  sec_range_a: assert property (r.st == MSC_CMP
    |-> flash_addr >= SEC_FIRST_ADDR && flash_addr <= SEC_LAST_ADDR)
    else $error("security read out of range");
  forced_baud_a: assert property (start && forced_mode && clk_en && r.st == MSC_IDLE
    |=> baud_div == BAUD_DIV)
    else $error("forced baud wrong");
  pass_all_eq_a: assert property ($rose(sec_pass) |-> r.all_eq && !r.locked)
    else $error("pass without full match");

  sequence trim_read_s;
    clk_en && flash_rd && flash_addr == TRIM_ADDR ##1 clk_en;
  endsequence

  sequence lock_read_s;
    clk_en && r.st == MSC_LOCK && !r.trim_phase && flash_rd ##1 clk_en;
  endsequence

  trim_applied_a: assert property (trim_read_s |=> osc_trim == $past(flash_data))
    else $error("stored trim not applied");
  lock_latch_a: assert property (lock_read_s |=> r.locked == is_zero($past(flash_data)))
    else $error("lock byte not decoded");
  zero_fail_a: assert property ($rose(done) && r.zeros > MAX_ZERO_BYTES |-> sec_fail)
    else $error("too many zeros did not fail");
  halt_quiet_a: assert property (mon_halt |-> !sec_pass && !sec_fail)
    else $error("halted monitor shows a result");
  pass_fail_a: assert property (sec_pass |-> !sec_fail)
    else $error("pass and fail together");
  erase_unlock_a: assert property (erase_go |-> !r.locked)
    else $error("erase left lock set");
  sec_order_a: assert property (r.st == MSC_CMP && flash_rd
    |-> flash_addr == SEC_FIRST_ADDR + 16'(r.idx))
    else $error("security read out of order");
endmodule

// ---- src/msc_pkg.sv ----
// Purpose: Constants for the monitor security check
// Assumes: 16-bit flash address, 8-bit data, 10 MHz ref_clk
// Notes: Baud divider derived from clock rate
package msc_pkg;
  localparam logic [15:0] EXT_LOCK_ADDR = 16'hfdff;
  localparam logic [15:0] SEC_FIRST_ADDR = 16'hfff6;
  localparam logic [15:0] SEC_LAST_ADDR = 16'hfffd;
  localparam logic [15:0] TRIM_ADDR = 16'hff80;
  localparam int SEC_BYTES = 8;
  localparam logic [3:0] MAX_ZERO_BYTES = 4'h5;
  localparam int CLK_HZ = 10000000;
  localparam int MON_BAUD = 9600;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / MON_BAUD);
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [3:0] IDX_RESET = 4'h0;
  typedef enum logic [5:0] {
    MSC_IDLE = 6'h01,
    MSC_LOCK = 6'h02,
    MSC_CMP = 6'h04,
    MSC_PASS = 6'h08,
    MSC_FAIL = 6'h10,
    MSC_HALT = 6'h20
  } msc_state_e;
endpackage

// ---- tb/msc_flash_model.sv ----
// Purpose: Flash array that the security check reads
// Assumes: Read data is valid the cycle after the read strobe
// Notes: Data line toggles when not read, so a stale byte reads inverted one cycle late and true again every second cycle
module msc_flash_model (
  input wire logic ref_clk, // Clock
  input wire logic flash_rd, // Read strobe
  input wire logic [15:0] flash_addr, // Read address
  input wire logic erase_go, // Mass erase pulse
  output logic [7:0] flash_data // Read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  initial flash_data = 8'h00;
  always @(posedge ref_clk) begin
    if (erase_go) begin
      foreach (mem[i]) mem[i] = 8'hff;
    end
    if (flash_rd) flash_data <= mem[flash_addr];
    else flash_data <= ~flash_data;
  end
endmodule

// ---- tb/msc_check_tb_top.sv ----
// Purpose: Self-checking bench for the monitor security check
// Assumes: Each check starts from a fresh reset
// Notes: Sticky halt forces a reset between checks
module msc_check_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import msc_pkg::*;
  logic ref_clk, rst, clk_en, start, forced_mode, host_valid, mass_erase_req;
  logic [7:0] host_byte, flash_data, osc_trim;
  logic flash_rd, erase_go, sec_pass, sec_fail, mon_halt, done;
  logic [15:0] flash_addr, baud_div;
  int failures, check_count;
  msc_check msc_check_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .start(start),
    .forced_mode(forced_mode), .host_valid(host_valid), .host_byte(host_byte),
    .mass_erase_req(mass_erase_req), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_data(flash_data), .erase_go(erase_go), .sec_pass(sec_pass), .sec_fail(sec_fail),
    .mon_halt(mon_halt), .done(done), .baud_div(baud_div), .osc_trim(osc_trim));
  msc_flash_model msc_flash_model_i (.ref_clk(ref_clk), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .erase_go(erase_go), .flash_data(flash_data));
  always #50 ref_clk = ~ref_clk;
  task automatic give_verdict();
    if (failures == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic await(input int what, input logic [15:0] a);
    for (int n = 0; n < 100; n++) begin
      @(negedge ref_clk);
      if (what == 0 && flash_rd === 1'b1 && flash_addr === a) return;
      if (what == 1 && done === 1'b1) return;
      if (what == 2 && erase_go === 1'b1) return;
    end
    failures++;
    give_verdict();
  endtask
  task automatic run(input bit fm, input int bad);
    int z, mism;
    bit ok, lock;
    logic [7:0] sup_q[$];
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    forced_mode <= fm;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    z = 0;
    mism = 0;
    for (int i = 0; i < 8; i++) begin
      sup_q.push_back(msc_flash_model_i.mem[16'hfff6 + i] ^ ((i == bad) ? 8'h01 : 8'h00));
      await(0, 16'hfff6 + 16'(i));
      // Strobe lands while the stored byte loads, so it must be ignored
      @(posedge ref_clk);
      host_valid <= 1'b1;
      host_byte <= ~sup_q[i];
      @(posedge ref_clk);
      host_byte <= sup_q[i];
      start <= (i == 3);
      @(posedge ref_clk);
      host_valid <= 1'b0;
      start <= 1'b0;
    end
    foreach (sup_q[j]) begin
      mism += (sup_q[j] != msc_flash_model_i.mem[16'hfff6 + j]);
      z += (msc_flash_model_i.mem[16'hfff6 + j] == 8'h00);
    end
    await(1, 16'h0000);
    lock = (msc_flash_model_i.mem[16'hfdff] == 8'h00);
    ok = (mism == 0) && (z <= 5);
    chk(16'(sec_pass), 16'(ok && !lock));
    chk(16'(sec_fail), 16'(!ok));
    chk(16'(mon_halt), 16'(ok && lock));
    if (fm) begin
      chk(baud_div, 16'(10000000 / 9600));
      chk(16'(osc_trim), 16'(msc_flash_model_i.mem[16'hff80]));
    end else begin
      chk(16'(osc_trim), 16'(TRIM_RESET));
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    {start, forced_mode, host_valid, mass_erase_req} = 4'h0;
    host_byte = 8'h00;
    void'($urandom(32'h0889));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 8; i++) msc_flash_model_i.mem[16'hfff6 + i] = 8'($urandom_range(1, 255));
      for (int i = 0; i < ((k == 3) ? 6 : (k == 4) ? 5 : 0); i++) msc_flash_model_i.mem[16'hfff6 + i] = 8'h00;
      msc_flash_model_i.mem[16'hfdff] = (k == 2 || k == 5) ? 8'h00 : 8'($urandom_range(1, 255));
      msc_flash_model_i.mem[16'hff80] = 8'($urandom);
      run(k[0], (k == 1 || k == 5) ? int'($urandom_range(0, 7)) : 8);
      if (k >= 4) begin
        @(posedge ref_clk);
        mass_erase_req <= 1'b1;
        if (k == 4) begin
          repeat (4) begin
            @(negedge ref_clk);
            chk(16'(erase_go), 16'h0000);
          end
        end else await(2, 16'h0000);
        @(posedge ref_clk);
        mass_erase_req <= 1'b0;
      end
    end
    // Frozen block must ignore a start strobe
    @(posedge ref_clk);
    clk_en <= 1'b0;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (3) begin
      @(negedge ref_clk);
      chk(16'(flash_rd), 16'h0000);
      chk(16'(done), 16'h0001);
    end
    @(posedge ref_clk);
    clk_en <= 1'b1;
    run(1'b0, 8);
    give_verdict();
  end
endmodule
